// [include/dsw_defs.vh]
// constants for the ddr write-mask port: widths, lane sizes, states
// assumes inclusion by bare name from every design file
`ifndef DSW_DEFS_VH
`define DSW_DEFS_VH
// ****************************************
// organisation and lanes
// ****************************************
`define DSW_DATA_W 36
`define DSW_NIB_W 4
`define DSW_BYTE_W 9
`define DSW_X8_W 8
`define DSW_NIB_MASKS 2
`define DSW_BYTE_MASKS 4
`define DSW_MASK_W 4
`define DSW_ADDR_W 18
`define DSW_DEPTH 64
`define DSW_IDX_W 6
// ****************************************
// fsm state codes (one hot)
// ****************************************
`define DSW_ST_IDLE 3'h1
`define DSW_ST_SECOND 3'h2
`define DSW_ST_COMMIT 3'h4
`define DSW_ZERO_MASK 4'h0
`endif

// [hdl/dsw_buf2.v]
// two-entry valid/ready buffer for burst words with their masks
// assumes a single clock and an async active-high reset
`timescale 1ns/1ps
`include "dsw_defs.vh"
module dsw_buf2 #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ****************************************
  // storage
  // ****************************************
  reg [WIDTH-1:0] mem_r [0:1]; // two slots
  reg wp_r; // write slot
  reg rp_r; // read slot
  reg [1:0] cnt_r; // occupancy
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data = mem_r[rp_r];
  // pointer and occupancy update
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      if (push && !pop) cnt_r <= cnt_r + 2'h1;
      else if (pop && !push) cnt_r <= cnt_r - 2'h1;
    end
  end
  // data slots, no reset needed
  always @(posedge clk) begin
    if (push) mem_r[wp_r] <= in_data;
  end
endmodule // dsw_buf2

// [hdl/dsw_array.v]
// flop storage array with per-lane write enables
// assumes lane enables are already decoded, one bit per data bit
`timescale 1ns/1ps
`include "dsw_defs.vh"
module dsw_array #(
  parameter WIDTH = 36,
  parameter DEPTH = 64,
  parameter IDX_W = 6
) (
  // clock
  input wire clk,
  // write side
  input wire wr_en,
  input wire [IDX_W-1:0] wr_idx,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] wr_bit_en,
  // read side
  input wire [IDX_W-1:0] rd_idx,
  output wire [WIDTH-1:0] rd_data
);
  // ****************************************
  // storage
  // ****************************************
  reg [WIDTH-1:0] mem_r [0:DEPTH-1]; // memory words
  assign rd_data = mem_r[rd_idx];
  // bitwise merge keeps unselected lanes intact
  always @(posedge clk) begin
    if (wr_en) mem_r[wr_idx] <= (mem_r[wr_idx] & ~wr_bit_en) | (wr_data & wr_bit_en);
  end
endmodule // dsw_array

// [hdl/dsw_port.v]
// write-data port of a ddr separate-io sram with load control
// assumes k and k-bar edges arrive as synchronous phase strobes on CLK_SYS
`timescale 1ns/1ps
`include "dsw_defs.vh"
// Notes on behaviour
// R1 - data sampled on both input clock edges
// R2 - low load strobe captures address and direction
// R3 - each transaction carries exactly two words
// R4 - x8 uses two active-low nibble masks
// R5 - nibble mask 0 bits 3:0, 1 bits 7:4
// R6 - unselected nibbles keep stored contents
// R7 - nibble mask sampled with its word
// R8 - high nibble mask ignores that nibble
// R9 - up to four active-low byte masks
// R10 - x18 byte masks cover 8:0 and 17:9
// R11 - x36 masks 2,3 cover 26:18, 35:27
// R12 - byte mask sampled with its word
// R13 - high byte mask ignores that byte
// R14 - direction high read, low write
// R15 - address sampled on positive clock edge
// R16 - word one on k, word two on k-bar
module dsw_port #(
  parameter DATA_W = `DSW_DATA_W,
  parameter ADDR_W = `DSW_ADDR_W,
  parameter DEPTH = `DSW_DEPTH,
  parameter IDX_W = `DSW_IDX_W
) (
  // system clock and reset
  CLK_SYS,
  SYS_RST,
  // input clock phase strobes
  K_RISE,
  KN_RISE,
  // transaction control
  LOAD_STROBE_N,
  RD_WR_SEL,
  ADDR,
  // write data and masks
  DATA_IN,
  NIBBLE_WRITE_MASK_N,
  BYTE_WRITE_MASK_N,
  // read-back of the array
  RB_ADDR,
  RB_DATA,
  // status
  WR_DONE,
  RD_LOADED,
  BUSY
);
  input wire CLK_SYS;
  input wire SYS_RST;
  input wire K_RISE;
  input wire KN_RISE;
  input wire LOAD_STROBE_N;
  input wire RD_WR_SEL;
  input wire [ADDR_W-1:0] ADDR;
  input wire [DATA_W-1:0] DATA_IN;
  input wire [`DSW_NIB_MASKS-1:0] NIBBLE_WRITE_MASK_N;
  input wire [`DSW_BYTE_MASKS-1:0] BYTE_WRITE_MASK_N;
  input wire [ADDR_W:0] RB_ADDR;
  output reg [DATA_W-1:0] RB_DATA;
  output reg WR_DONE;
  output reg RD_LOADED;
  output reg BUSY;

  // ****************************************
  // lane decode
  // ****************************************
  // expands active-low masks into a per-bit write enable
  function [DATA_W-1:0] lane_en;
    input integer width;
    input [`DSW_NIB_MASKS-1:0] nmask_n;
    input [`DSW_BYTE_MASKS-1:0] bmask_n;
    integer i;
    begin
      lane_en = {DATA_W{1'b0}};
      for (i = 0; i < DATA_W; i = i + 1) begin
        if (width == `DSW_X8_W) begin
          // nibble lane i/4, active low [R4] [R5] [R8]
          if (i < `DSW_X8_W) lane_en[i] = ~nmask_n[i / `DSW_NIB_W];
        end else if (i < width) begin
          // byte lane i/9, active low [R9] [R10] [R11] [R13]
          lane_en[i] = ~bmask_n[i / `DSW_BYTE_W];
        end
      end
    end
  endfunction

  // ****************************************
  // transaction state
  // ****************************************
  localparam ST_IDLE = `DSW_ST_IDLE;
  localparam ST_SECOND = `DSW_ST_SECOND;
  localparam ST_COMMIT = `DSW_ST_COMMIT;
  localparam BW = DATA_W + DATA_W;

  reg [2:0] st_r; // one-hot state
  reg [2:0] st_nxt; // next state
  reg [ADDR_W-1:0] addr_r; // loaded address
  reg [DATA_W-1:0] w0_r; // first word
  reg [DATA_W-1:0] e0_r; // first word lane enables
  reg commit_r; // pushes one word pair
  reg [ADDR_W-1:0] caddr_r; // address for the pair
  reg [DATA_W-1:0] w1_r; // second word
  reg [DATA_W-1:0] e1_r; // second word lane enables

  wire load = !LOAD_STROBE_N && K_RISE; // [R2] [R15]
  wire is_write = load && !RD_WR_SEL; // [R14]
  wire [DATA_W-1:0] en_now = lane_en(DATA_W, NIBBLE_WRITE_MASK_N, BYTE_WRITE_MASK_N); // [R7] [R12]

  // next-state logic
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        // first word taken with the load on k [R16]
        if (is_write) st_nxt = ST_SECOND;
      end
      ST_SECOND: begin
        // second word on the following k-bar, burst of two [R3]
        if (KN_RISE) st_nxt = ST_COMMIT;
      end
      ST_COMMIT: begin
        st_nxt = ST_IDLE;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // capture of address, words and masks [R1]
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      addr_r <= {ADDR_W{1'b0}};
      w0_r <= {DATA_W{1'b0}};
      e0_r <= {DATA_W{1'b0}};
      w1_r <= {DATA_W{1'b0}};
      e1_r <= {DATA_W{1'b0}};
      commit_r <= 1'b0;
      caddr_r <= {ADDR_W{1'b0}};
      RD_LOADED <= 1'b0;
      BUSY <= 1'b0;
    end else begin
      st_r <= st_nxt;
      commit_r <= 1'b0;
      RD_LOADED <= load && RD_WR_SEL; // read direction noted only [R14]
      BUSY <= (st_nxt != ST_IDLE);
      if (st_r == ST_IDLE && is_write) begin
        // word one and its masks on k [R16] [R2]
        addr_r <= ADDR;
        w0_r <= DATA_IN;
        e0_r <= en_now;
      end
      if (st_r == ST_SECOND && KN_RISE) begin
        // word two and its masks on k-bar [R16] [R3]
        w1_r <= DATA_IN;
        e1_r <= en_now;
        caddr_r <= addr_r;
        commit_r <= 1'b1;
      end
    end
  end

  // ****************************************
  // buffer and array
  // ****************************************
  wire buf_in_ready; // pair accepted
  wire buf_out_valid; // pair waiting
  wire [ADDR_W+4*DATA_W-1:0] buf_out; // buffered pair
  wire [DATA_W-1:0] rd_word; // array read value
  reg wr_phase_r; // 0 first word, 1 second word

  dsw_buf2 #(
    .WIDTH(ADDR_W + 4 * DATA_W)
  ) u_buf (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .in_valid(commit_r),
    .in_ready(buf_in_ready),
    .in_data({caddr_r, w1_r, e1_r, w0_r, e0_r}),
    .out_valid(buf_out_valid),
    .out_ready(wr_phase_r),
    .out_data(buf_out)
  );

  wire [ADDR_W-1:0] b_addr = buf_out[ADDR_W+4*DATA_W-1:4*DATA_W];
  wire [DATA_W-1:0] b_w1 = buf_out[4*DATA_W-1:3*DATA_W];
  wire [DATA_W-1:0] b_e1 = buf_out[3*DATA_W-1:BW];
  wire [DATA_W-1:0] b_w0 = buf_out[BW-1:DATA_W];
  wire [DATA_W-1:0] b_e0 = buf_out[DATA_W-1:0];
  // two array words per address, low index bit picks the word
  wire [IDX_W-1:0] wr_idx = {b_addr[IDX_W-2:0], wr_phase_r};

  // word alternation drains one pair over two cycles
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_phase_r <= 1'b0;
      WR_DONE <= 1'b0;
    end else begin
      WR_DONE <= buf_out_valid && wr_phase_r;
      if (buf_out_valid) wr_phase_r <= ~wr_phase_r;
    end
  end

  // masked lanes keep their stored value [R6] [R8] [R13]
  dsw_array #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH),
    .IDX_W(IDX_W)
  ) u_arr (
    .clk(CLK_SYS),
    .wr_en(buf_out_valid),
    .wr_idx(wr_idx),
    .wr_data(wr_phase_r ? b_w1 : b_w0),
    .wr_bit_en(wr_phase_r ? b_e1 : b_e0),
    .rd_idx(RB_ADDR[IDX_W-1:0]),
    .rd_data(rd_word)
  );

  // registered read-back
  always @(posedge CLK_SYS or posedge SYS_RST) begin
    if (SYS_RST) RB_DATA <= {DATA_W{1'b0}};
    else RB_DATA <= rd_word;
  end
endmodule // dsw_port

// [bench/dsw_port_sva.sv]
// checker for the write-mask port: load, burst and status timing
// assumes it is bound to dsw_port and sees only its ports
`timescale 1ns/1ps
module dsw_port_sva (
  // clock and reset
  input wire CLK_SYS,
  input wire SYS_RST,
  // load control
  input wire K_RISE,
  input wire KN_RISE,
  input wire LOAD_STROBE_N,
  input wire RD_WR_SEL,
  // status
  input wire WR_DONE,
  input wire RD_LOADED,
  input wire BUSY
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  wire ld_w = K_RISE && !LOAD_STROBE_N && !RD_WR_SEL && !BUSY; // write load taken
  wire ld_r = K_RISE && !LOAD_STROBE_N && RD_WR_SEL && !BUSY; // read load taken
  property p_wr_busy; ld_w |=> BUSY; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("no busy after write load");
  property p_rd_pulse; ld_r |-> ##[1:2] RD_LOADED; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read load not flagged");
  property p_rd_idle; ld_r |=> !BUSY; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("busy after read load");
  property p_done; ld_w ##1 KN_RISE |-> ##[4:5] WR_DONE; endproperty
  a_done: assert property (p_done) else $error("burst never completed");
  property p_done_pulse; WR_DONE |=> !WR_DONE; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done held too long");
  property p_rdl_pulse; RD_LOADED |=> !RD_LOADED; endproperty
  a_rdl_pulse: assert property (p_rdl_pulse) else $error("read flag held too long");
  property p_done_cause; WR_DONE |-> $past(KN_RISE, 4) || $past(KN_RISE, 5); endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without second word");
  property p_busy_end; BUSY && KN_RISE |-> ##[1:2] !BUSY; endproperty
  a_busy_end: assert property (p_busy_end) else $error("burst longer than two words");
endmodule // dsw_port_sva

// [bench/dsw_ctl_model.sv]
// memory controller model: load strobe, k strobes, data, byte masks
// assumes the bench calls its tasks one at a time on the shared clock
`timescale 1ns/1ps
module dsw_ctl_model (
  // clock
  input wire clk,
  // controller outputs
  output logic k_rise,
  output logic kn_rise,
  output logic ld_n,
  output logic rw,
  output logic [17:0] addr,
  output logic [35:0] data,
  output logic [3:0] bmask_n
);
  // ****************************************
  // transfers
  // ****************************************
  initial begin
    k_rise = 0; kn_rise = 0; ld_n = 1; rw = 0;
    addr = 18'h0; data = 36'h0; bmask_n = 4'hf;
  end
  // write burst: word0 on k, word1 on k-bar, then released lines toggle
  task wr(input logic [17:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
    @(posedge clk) #1;
    k_rise = 1; ld_n = 0; rw = 0; addr = a; data = d0; bmask_n = m0;
    @(posedge clk) #1;
    k_rise = 0; ld_n = 1; addr = ~a; kn_rise = 1; data = d1; bmask_n = m1;
    @(posedge clk) #1;
    kn_rise = 0; data = ~d1; bmask_n = ~m1;
    repeat (6) @(posedge clk);
  endtask
  // read load: direction high, no data phase
  task rd(input logic [17:0] a);
    @(posedge clk) #1;
    k_rise = 1; ld_n = 0; rw = 1; addr = a; data = ~data;
    @(posedge clk) #1;
    k_rise = 0; ld_n = 1; rw = 0; addr = ~a;
    repeat (6) @(posedge clk);
  endtask
endmodule // dsw_ctl_model

// [bench/test_dsw_port.sv]
// self-checking bench for dsw_port at the 36-bit and 8-bit organisations
// assumes dsw_port, dsw_ctl_model and the checker are compiled first
`timescale 1ns/1ps
module test_dsw_port;
  // ****************************************
  // clock, reset and wiring
  // ****************************************
  logic CLK_SYS = 0;
  logic SYS_RST = 1;
  logic [18:0] RB_ADDR = 19'h0;
  wire k, kn, ldn, rw, done, rdl, busy;
  wire [17:0] addr;
  wire [35:0] din, rdat;
  wire [3:0] bm;
  integer num_errors = 0, num_checks = 0, done_cnt = 0, rdl_cnt = 0;
  logic [35:0] e0, e1;
  logic [7:0] f0, f1, nm; // expected x8 words and nibble enables of word0
  logic [3:0] m; // lane under test
  wire [7:0] rdat8;
  initial forever #50 CLK_SYS = ~CLK_SYS;
  dsw_ctl_model u_ctl (.clk(CLK_SYS), .k_rise(k), .kn_rise(kn), .ld_n(ldn), .rw(rw),
    .addr(addr), .data(din), .bmask_n(bm));
  dsw_port dut_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .K_RISE(k), .KN_RISE(kn),
    .LOAD_STROBE_N(ldn), .RD_WR_SEL(rw), .ADDR(addr), .DATA_IN(din),
    .NIBBLE_WRITE_MASK_N(2'h3), .BYTE_WRITE_MASK_N(bm), .RB_ADDR(RB_ADDR),
    .RB_DATA(rdat), .WR_DONE(done), .RD_LOADED(rdl), .BUSY(busy));
  // second port at the 8-bit organisation, nibble masks from the low mask lines
  dsw_port #(.DATA_W(8)) dut8_u (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .K_RISE(k),
    .KN_RISE(kn), .LOAD_STROBE_N(ldn), .RD_WR_SEL(rw), .ADDR(addr), .DATA_IN(din[7:0]),
    .NIBBLE_WRITE_MASK_N(bm[1:0]), .BYTE_WRITE_MASK_N(bm), .RB_ADDR(RB_ADDR),
    .RB_DATA(rdat8), .WR_DONE(), .RD_LOADED(), .BUSY());
  // count status pulses
  always @(posedge CLK_SYS) begin
    if (done === 1'b1) done_cnt++;
    if (rdl === 1'b1) rdl_cnt++;
  end
  // ****************************************
  // helpers and scenarios
  // ****************************************
  task chk(input logic [35:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // read back one array word, one cycle of latency
  task rb(input logic [5:0] i, input logic [35:0] e, input logic [7:0] f);
    @(posedge CLK_SYS) #1;
    RB_ADDR = {13'h0, i};
    @(posedge CLK_SYS) #1;
    chk(rdat, e);
    chk({28'h0, rdat8}, {28'h0, f});
  endtask
  task test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one lane enabled in word0, one lane held off in word1, inverted data so held lanes show
  task t_lanes;
    for (int n = 0; n < 4; n++) begin
      m = 4'h1 << n;
      nm = {{4{m[1]}}, {4{m[0]}}};
      u_ctl.wr(18'h3, ~e0, ~e1, ~m, m);
      f0 = (~e0[7:0] & nm) | (f0 & ~nm);
      f1 = (~e1[7:0] & ~nm) | (f1 & nm);
      e0 = e0 ^ (36'h1ff << (9 * n));
      e1 = e1 ^ ~(36'h1ff << (9 * n));
      rb(6'h6, e0, f0);
      rb(6'h7, e1, f1);
    end
  endtask
  initial begin
    #500000;
    num_errors++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge CLK_SYS);
    #1 SYS_RST = 0;
    e0 = 36'h123456789;
    e1 = 36'hfedcba987;
    f0 = e0[7:0];
    f1 = e1[7:0];
    u_ctl.wr(18'h3, e0, e1, 4'h0, 4'h0);
    rb(6'h6, e0, f0);
    rb(6'h7, e1, f1);
    chk(done_cnt, 1);
    t_lanes;
    chk(done_cnt, 5);
    u_ctl.rd(18'h3);
    chk(rdl_cnt, 1);
    chk(done_cnt, 5);
    rb(6'h6, e0, f0);
    test_done;
  end
endmodule // test_dsw_port
bind dsw_port dsw_port_sva u_sva (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .K_RISE(K_RISE),
  .KN_RISE(KN_RISE), .LOAD_STROBE_N(LOAD_STROBE_N), .RD_WR_SEL(RD_WR_SEL),
  .WR_DONE(WR_DONE), .RD_LOADED(RD_LOADED), .BUSY(BUSY));
